// ---- design/cpu_isa_decode_tail.sv ----
// instruction tail unit: decode, execute and wishbone register access
`timescale 1ns/1ps
`include "tail_defs.svh"
module cpu_isa_decode_tail (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             mem_rd_o,
    output logic      [31:0] mem_adr_o,
    input  wire logic        mem_ack_i,
    input  wire logic [31:0] mem_dat_i
);
    // ****************************************
    // decode
    // ****************************************
    tail_pkg::state_t r;
    tail_pkg::state_t n;
    tail_pkg::op_t    dop;
    logic [15:0]      h;
    logic [15:0]      w2;
    logic [4:0]       f1;
    logic [4:0]       f2;
    logic [31:0]      g1;
    logic [31:0]      g2;
    logic [11:0]      lst;
    logic [3:0]       nn;
    logic [3:0]       nn1;
    logic [1:0]       ff;
    logic [8:0]       imm9;
    logic [21:0]      disp22;
    logic [31:0]      epv;
    logic [31:0]      md;
    logic [31:0]      bsh;
    logic [15:0]      hw;
    logic [31:0]      hx;
    logic             zb;
    logic [31:0]      res;
    logic [31:0]      adr_s;
    logic [4:0]       base;
    logic             memop;
    logic             fin;
    logic             st;

    assign h      = r.insn[15:0];
    assign w2     = r.insn[31:16];
    assign f1     = h[15:11];
    assign f2     = h[4:0];
    assign g1     = r.gpr[f1];
    assign g2     = r.gpr[f2];
    assign lst    = {h[0], w2[15:5]};
    assign ff     = r.insn[20:19];
    assign imm9   = {w2[5:2], h[4:0]};
    assign disp22 = {h[5:0], w2[15:1], 1'h0};

    always_comb begin
        nn = 4'h0;
        for (int i = 0; i < 12; i++) begin
            nn = nn + {3'h0, lst[i]};
        end
    end
    assign nn1 = (nn == 4'h0) ? 4'h1 : nn;

    assign epv = (ff == 2'h0) ? r.gpr[3] :
                 (ff == 2'h1) ? {{16{r.ext[15]}}, r.ext[15:0]} :
                 (ff == 2'h2) ? {r.ext[15:0], 16'h0000} : r.ext;

    function automatic tail_pkg::op_t dec(input logic [15:0] a, input logic [15:0] b);
        dec = tail_pkg::op_none;
        if (a[15:5] == 11'h002 && a[4:0] != 5'h00) begin
            dec = tail_pkg::op_table_jump;
        end else if (a[15:5] == 11'h005 && a[4:0] != 5'h00) begin
            dec = tail_pkg::sign_ext_byte_op;
        end else if (a[15:5] == 11'h007 && a[4:0] != 5'h00) begin
            dec = tail_pkg::sign_ext_half_op;
        end else if (a[15:5] == 11'h004 && a[4:0] != 5'h00) begin
            dec = tail_pkg::zero_ext_byte_op;
        end else if (a[15:5] == 11'h006 && a[4:0] != 5'h00) begin
            dec = tail_pkg::zero_ext_half_op;
        end else if (a[15:5] == 11'h03F && b == 16'h0100) begin
            dec = tail_pkg::op_trap;
        end else if (a[15:14] == 2'h3 && a[10:5] == 6'h3E) begin
            dec = tail_pkg::memory_bit_test_op;
        end else if (a[10:5] == 6'h3F && b == 16'h00E6) begin
            dec = tail_pkg::op_reg_bit_test;
        end else if (a[10:5] == 6'h3F && b == 16'h0020) begin
            dec = tail_pkg::op_sr_load;
        end else if (a[10:5] == 6'h3F && b == 16'h0040) begin
            dec = tail_pkg::op_sr_store;
        end else if (a[15:6] == 10'h01E && b[2:0] == 3'h3) begin
            dec = tail_pkg::op_list;
        end else if (a[10:5] == 6'h35) begin
            dec = tail_pkg::xor_immediate_op;
        end else if (a[10:5] == 6'h39 && b[0]) begin
            dec = tail_pkg::op_load;
        end else if (a[10:7] == 4'hA && !a[0]) begin
            dec = tail_pkg::op_short_load;
        end
    endfunction
    assign dop = dec(h, w2);

    function automatic logic [4:0] bclk(input tail_pkg::op_t o, input logic [3:0] k,
                                        input logic [1:0] f, input logic p);
        case (o)
            tail_pkg::op_table_jump: bclk = `CLK_SWITCH;
            tail_pkg::op_trap: bclk = `CLK_TRAP;
            tail_pkg::memory_bit_test_op, tail_pkg::op_reg_bit_test: bclk = `CLK_BIT;
            tail_pkg::op_load: bclk = `CLK_LD;
            tail_pkg::op_list: begin
                bclk = {1'h0, k} + ((f == 2'h3) ? `CLK_IMM32 :
                                    (f == 2'h0) ? `CLK_SP : `CLK_IMM16);
            end
            tail_pkg::op_sr_load, tail_pkg::op_sr_store: begin
                bclk = p ? `CLK_PSWDLY : `CLK_ONE;
            end
            default: bclk = `CLK_ONE;
        endcase
    endfunction
    assign base = bclk(dop, nn1, ff, r.pswr);

    assign memop = dop inside {tail_pkg::op_table_jump, tail_pkg::memory_bit_test_op,
                               tail_pkg::op_reg_bit_test, tail_pkg::op_short_load,
                               tail_pkg::op_load};

    always_comb begin
        case (dop)
            tail_pkg::op_table_jump: begin
                adr_s = r.pc + 32'h0000_0002 + {g2[30:0], 1'h0};
            end
            tail_pkg::memory_bit_test_op: adr_s = g2 + {{16{w2[15]}}, w2};
            tail_pkg::op_reg_bit_test: adr_s = g2;
            tail_pkg::op_short_load: adr_s = r.ep + {24'h00_0000, h[6:1], 2'h0};
            tail_pkg::op_load: adr_s = g2 + {{16{w2[15]}}, w2[15:1], 1'h0};
            default: adr_s = 32'h0000_0000;
        endcase
    end

    assign md  = (r.rd && mem_ack_i) ? mem_dat_i : r.mdat;
    assign bsh = md >> {r.adr[1:0], 3'h0};
    assign hw  = r.adr[1] ? md[31:16] : md[15:0];
    assign hx  = {{16{hw[15]}}, hw};
    assign zb  = ~bsh[r.bitn];
    assign res = g2 ^ {16'h0000, w2};

    function automatic logic [31:0] wm(input logic [31:0] o, input logic [31:0] d,
                                       input logic [3:0] s);
        wm = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                wm[8*i +: 8] = d[8*i +: 8];
            end
        end
    endfunction

    // ****************************************
    // bus slave and engine
    // ****************************************
    always_comb begin
        n     = r;
        n.ack = 1'h0;
        st    = 1'h0;
        fin   = 1'h0;
        if (wb_cyc_i && wb_stb_i && !r.ack) begin
            n.ack = 1'h1;
            n.dat = 32'h0000_0000;
            if (wb_we_i) begin
                if (wb_adr_i == `A_STAT) begin
                    if (wb_sel_i[0] && wb_dat_i[1]) n.done = 1'h0;
                    if (wb_sel_i[0] && wb_dat_i[2]) n.ill = 1'h0;
                end else if (!r.busy) begin
                    if (wb_adr_i == `A_INSN) begin
                        n.insn = wm(r.insn, wb_dat_i, wb_sel_i);
                    end else if (wb_adr_i == `A_EXT) begin
                        n.ext = wm(r.ext, wb_dat_i, wb_sel_i);
                    end else if (wb_adr_i == `A_CTRL) begin
                        st = wb_sel_i[0] & wb_dat_i[0];
                    end else if (wb_adr_i == `A_PC) begin
                        n.pc = wm(r.pc, wb_dat_i, wb_sel_i);
                    end else if (wb_adr_i == `A_PSW) begin
                        n.program_status_word  = wm(r.program_status_word, wb_dat_i, wb_sel_i);
                        n.pswr = 1'h1;
                    end else if (wb_adr_i == `A_EP) begin
                        n.ep = wm(r.ep, wb_dat_i, wb_sel_i);
                    end else if (wb_adr_i[7]) begin
                        n.gpr[wb_adr_i[6:2]] = wm(r.gpr[wb_adr_i[6:2]], wb_dat_i, wb_sel_i);
                    end
                end
            end else begin
                if (wb_adr_i == `A_INSN) begin
                    n.dat = r.insn;
                end else if (wb_adr_i == `A_EXT) begin
                    n.dat = r.ext;
                end else if (wb_adr_i == `A_STAT) begin
                    n.dat = {28'h000_0000, r.pswr, r.ill, r.done, r.busy};
                end else if (wb_adr_i == `A_PC) begin
                    n.dat = r.pc;
                end else if (wb_adr_i == `A_PSW) begin
                    n.dat = r.program_status_word;
                end else if (wb_adr_i == `A_EXCEPTION_RETURN_PC) begin
                    n.dat = r.exception_return_pc;
                end else if (wb_adr_i == `A_EXCEPTION_SAVED_STATUS) begin
                    n.dat = r.exception_saved_status;
                end else if (wb_adr_i == `A_ECR) begin
                    n.dat = r.ecr;
                end else if (wb_adr_i == `A_EP) begin
                    n.dat = r.ep;
                end else if (wb_adr_i == `A_CYC) begin
                    n.dat = {16'h0000, r.wt, r.cyc};
                end else if (wb_adr_i == `A_FLD) begin
                    n.dat = {22'h00_0000, w2[0], imm9};
                end else if (wb_adr_i == `A_DSP) begin
                    n.dat = {{10{disp22[21]}}, disp22};
                end else if (wb_adr_i[7]) begin
                    n.dat = r.gpr[wb_adr_i[6:2]];
                end
            end
        end
        case (r.fsm)
            tail_pkg::st_idle: begin
                if (st && dop == tail_pkg::op_none) begin
                    n.ill = 1'h1;
                end else if (st) begin
                    n.fsm  = tail_pkg::st_run;
                    n.busy = 1'h1;
                    n.op   = dop;
                    n.cnt  = base;
                    n.cyc  = 8'h00;
                    n.wt   = 8'h00;
                    n.rd   = memop;
                    n.adr  = adr_s;
                    n.bitn = (dop == tail_pkg::op_reg_bit_test) ? g1[2:0] : h[13:11];
                end
            end
            tail_pkg::st_run: begin
                if (r.rd && !mem_ack_i) begin
                    n.wt  = r.wt + 8'h01;
                    n.cyc = r.cyc + 8'h01;
                end else if (r.cnt != 5'h01) begin
                    n.cnt   = r.cnt - 5'h01;
                    n.cyc   = r.cyc + 8'h01;
                    n.rd    = 1'h0;
                    n.mdat  = md;
                end else begin
                    fin    = 1'h1;
                    n.fsm  = tail_pkg::st_idle;
                    n.busy = 1'h0;
                    n.done = 1'h1;
                    n.rd   = 1'h0;
                    n.pswr = 1'h0;
                    n.pc   = r.pc + 32'h0000_0004;
                    case (r.op)
                        tail_pkg::op_table_jump: begin
                            n.pc = r.pc + 32'h0000_0002 + {hx[30:0], 1'h0};
                        end
                        tail_pkg::sign_ext_byte_op: begin
                            n.gpr[f2] = {{24{g2[7]}}, g2[7:0]};
                            n.pc      = r.pc + 32'h0000_0002;
                        end
                        tail_pkg::sign_ext_half_op: begin
                            n.gpr[f2] = {{16{g2[15]}}, g2[15:0]};
                            n.pc      = r.pc + 32'h0000_0002;
                        end
                        tail_pkg::zero_ext_byte_op: begin
                            n.gpr[f2] = {24'h00_0000, g2[7:0]};
                            n.pc      = r.pc + 32'h0000_0002;
                        end
                        tail_pkg::zero_ext_half_op: begin
                            n.gpr[f2] = {16'h0000, g2[15:0]};
                            n.pc      = r.pc + 32'h0000_0002;
                        end
                        tail_pkg::op_trap: begin
                            n.exception_return_pc  = r.pc + 32'h0000_0004;
                            n.exception_saved_status = r.program_status_word;
                            n.ecr   = {r.ecr[31:16], `TRAP_CODE + {11'h000, f2}};
                            n.program_status_word[`EXCEPTION_PENDING_BIT] = 1'h1;
                            n.program_status_word[`INTERRUPT_DISABLE_BIT] = 1'h1;
                            n.pswr  = 1'h1;
                            n.pc    = f2[4] ? `TRAP_HI : `TRAP_LO;
                        end
                        tail_pkg::memory_bit_test_op, tail_pkg::op_reg_bit_test: begin
                            n.program_status_word[`PSW_Z] = zb;
                            n.pswr        = 1'h1;
                        end
                        tail_pkg::xor_immediate_op: begin
                            n.gpr[f1]      = res;
                            n.program_status_word[`PSW_OV] = 1'h0;
                            n.program_status_word[`PSW_S]  = res[31];
                            n.program_status_word[`PSW_Z]  = (res == 32'h0000_0000);
                            n.pswr         = 1'h1;
                        end
                        tail_pkg::op_short_load: begin
                            n.gpr[f1] = md;
                            n.pc      = r.pc + 32'h0000_0002;
                        end
                        tail_pkg::op_load: n.gpr[f1] = md;
                        tail_pkg::op_list: begin
                            n.ep = epv;
                            n.pc = r.pc + ((ff == 2'h0) ? 32'h0000_0004 :
                                           (ff == 2'h3) ? 32'h0000_0008 : 32'h0000_0006);
                        end
                        tail_pkg::op_sr_load: begin
                            if (f1 == `SR_EXCEPTION_RETURN_PC) n.exception_return_pc = g2;
                            else if (f1 == `SR_EXCEPTION_SAVED_STATUS) n.exception_saved_status = g2;
                            else if (f1 == `SR_ECR) n.ecr = g2;
                            else if (f1 == `SR_PSW) begin
                                n.program_status_word  = g2;
                                n.pswr = 1'h1;
                            end
                        end
                        tail_pkg::op_sr_store: begin
                            if (f2 == `SR_EXCEPTION_RETURN_PC) n.gpr[f1] = r.exception_return_pc;
                            else if (f2 == `SR_EXCEPTION_SAVED_STATUS) n.gpr[f1] = r.exception_saved_status;
                            else if (f2 == `SR_ECR) n.gpr[f1] = r.ecr;
                            else if (f2 == `SR_PSW) n.gpr[f1] = r.program_status_word;
                            else n.gpr[f1] = 32'h0000_0000;
                        end
                        default: n.pc = r.pc;
                    endcase
                end
            end
            default: n.fsm = tail_pkg::st_idle;
        endcase
        n.gpr[0] = 32'h0000_0000;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r     <= '0;
            r.program_status_word <= `PSW_RST;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o  = r.dat;
    assign wb_ack_o  = r.ack;
    assign mem_rd_o  = r.rd;
    assign mem_adr_o = r.adr;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_switch_addr: assert property (r.busy && r.op == tail_pkg::op_table_jump && r.rd
        |-> r.adr == r.pc + 32'h0000_0002 + {g2[30:0], 1'h0})
        else $error("table address wrong");
    a_switch_time: assert property (fin && r.op == tail_pkg::op_table_jump
        |-> r.cyc - r.wt == 8'h04 ##1 r.pc == $past(r.pc) + 32'h0000_0002 +
            {$past(hx[30:0]), 1'h0})
        else $error("table jump wrong");
    a_sext_byte: assert property (fin && r.op == tail_pkg::sign_ext_byte_op
        |=> r.gpr[f2] == {{24{$past(g2[7])}}, $past(g2[7:0])})
        else $error("byte sign extension wrong");
    a_ext_flags: assert property (fin && r.op inside {tail_pkg::sign_ext_byte_op,
        tail_pkg::sign_ext_half_op, tail_pkg::zero_ext_byte_op, tail_pkg::zero_ext_half_op}
        |-> r.cyc == 8'h00 ##1 r.program_status_word == $past(r.program_status_word))
        else $error("extension timing or flags wrong");
    a_trap_entry: assert property (fin && r.op == tail_pkg::op_trap |-> r.cyc == 8'h02
        ##1 (r.exception_return_pc == $past(r.pc) + 32'h0000_0004 && r.exception_saved_status == $past(r.program_status_word)
        && r.program_status_word[`EXCEPTION_PENDING_BIT] && r.program_status_word[`INTERRUPT_DISABLE_BIT]))
        else $error("trap entry wrong");
    a_trap_vector: assert property (fin && r.op == tail_pkg::op_trap
        |=> r.pc == ($past(f2[4]) ? `TRAP_HI : `TRAP_LO))
        else $error("trap vector wrong");
    a_bit_zflag: assert property (fin && r.op inside {tail_pkg::memory_bit_test_op,
        tail_pkg::op_reg_bit_test} |=> r.program_status_word[`PSW_Z] == $past(zb))
        else $error("bit test flag wrong");
    a_bit_time: assert property (fin && r.op inside {tail_pkg::memory_bit_test_op,
        tail_pkg::op_reg_bit_test} |-> r.cyc - r.wt == 8'h02)
        else $error("bit test timing wrong");
    a_xor_immediate_op_flags: assert property (fin && r.op == tail_pkg::xor_immediate_op
        |=> !r.program_status_word[`PSW_OV] && r.program_status_word[`PSW_Z] == ($past(res) == 32'h0000_0000))
        else $error("xor immediate flags wrong");
    a_psw_delay: assert property (fin && r.op inside {tail_pkg::op_sr_load,
        tail_pkg::op_sr_store} |-> r.cyc == (r.pswr ? 8'h02 : 8'h00))
        else $error("status delay wrong");
    a_load_time: assert property (fin && r.op == tail_pkg::op_load
        |-> r.cyc - r.wt == 8'h01)
        else $error("load timing wrong");
    a_list_time: assert property (fin && r.op == tail_pkg::op_list && ff == 2'h3
        |-> r.cyc + 8'h01 == {4'h0, nn1} + 8'h03 ##1 r.ep == $past(epv))
        else $error("list timing wrong");
    a_reject_zero: assert property (st && h[15:8] == 8'h00 && h[7:5] inside {3'h2, 3'h4,
        3'h5, 3'h6, 3'h7} && f2 == 5'h00 |=> r.ill && !r.busy)
        else $error("zero register field decoded");

    c_switch_done: cover property (fin && r.op == tail_pkg::op_table_jump);
    c_trap_high: cover property (fin && r.op == tail_pkg::op_trap && f2[4]);
    c_bit_wait: cover property (fin && r.op == tail_pkg::memory_bit_test_op && r.wt != 8'h00);
    c_list_imm32: cover property (fin && r.op == tail_pkg::op_list && ff == 2'h3);
endmodule // cpu_isa_decode_tail

// ---- design/tail_defs.svh ----
// offsets, field positions, reset values and clock counts of the instruction tail unit
`ifndef TAIL_DEFS_SVH
`define TAIL_DEFS_SVH
`define A_INSN 8'h00
`define A_EXT 8'h04
`define A_CTRL 8'h08
`define A_STAT 8'h0C
`define A_PC 8'h10
`define A_PSW 8'h14
`define A_EXCEPTION_RETURN_PC 8'h18
`define A_EXCEPTION_SAVED_STATUS 8'h1C
`define A_ECR 8'h20
`define A_EP 8'h24
`define A_CYC 8'h28
`define A_FLD 8'h2C
`define A_DSP 8'h30
`define PSW_Z 0
`define PSW_S 1
`define PSW_OV 2
`define INTERRUPT_DISABLE_BIT 5
`define EXCEPTION_PENDING_BIT 6
`define PSW_RST 32'h0000_0020
`define SR_EXCEPTION_RETURN_PC 5'h00
`define SR_EXCEPTION_SAVED_STATUS 5'h01
`define SR_ECR 5'h04
`define SR_PSW 5'h05
`define TRAP_LO 32'h0000_0040
`define TRAP_HI 32'h0000_0050
`define TRAP_CODE 16'h0040
`define CLK_ONE 5'h01
`define CLK_LD 5'h02
`define CLK_BIT 5'h03
`define CLK_TRAP 5'h03
`define CLK_SWITCH 5'h05
`define CLK_PSWDLY 5'h03
`define CLK_SP 5'h01
`define CLK_IMM16 5'h02
`define CLK_IMM32 5'h03
`endif

// ---- design/tail_pkg.sv ----
// types of the instruction tail unit
package tail_pkg;
    typedef enum logic {st_idle, st_run} fsm_t;
    typedef enum logic [3:0] {
        op_none, op_table_jump, sign_ext_byte_op, sign_ext_half_op,
        zero_ext_byte_op, zero_ext_half_op, op_trap, memory_bit_test_op,
        op_reg_bit_test, xor_immediate_op, op_short_load, op_load,
        op_list, op_sr_load, op_sr_store
    } op_t;
    typedef struct packed {
        fsm_t              fsm;
        op_t               op;
        logic [31:0]       insn;
        logic [31:0]       ext;
        logic [31:0]       pc;
        logic [31:0]       program_status_word;
        logic [31:0]       exception_return_pc;
        logic [31:0]       exception_saved_status;
        logic [31:0]       ecr;
        logic [31:0]       ep;
        logic [31:0]       adr;
        logic [31:0]       mdat;
        logic [31:0]       dat;
        logic [31:0][31:0] gpr;
        logic [4:0]        cnt;
        logic [7:0]        cyc;
        logic [7:0]        wt;
        logic [2:0]        bitn;
        logic              busy;
        logic              done;
        logic              ill;
        logic              pswr;
        logic              ack;
        logic              rd;
    } state_t;
endpackage

// ---- test/tail_mem_model.sv ----
// data memory model answering the unit's reads after a set number of wait states
`timescale 1ns/1ps
module tail_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  waits_i,
    input  wire logic [31:0] word_i,
    output logic             ack_o,
    output logic      [31:0] dat_o
);
    logic [7:0] cnt_r;
    always_ff @(posedge clk_i) cnt_r <= rd_i ? cnt_r + 8'h01 : 8'h00;
    assign ack_o = rd_i && (cnt_r >= waits_i);
    // while a read waits, and for one cycle after it, the data lines carry a moving pattern; otherwise with no read they carry the inverted word
    assign dat_o = ack_o ? word_i : ~word_i ^ {4{cnt_r}};
endmodule // tail_mem_model

// ---- test/test_cpu_isa_decode_tail.sv ----
// self-checking bench for the instruction tail unit
`timescale 1ns/1ps
`include "tail_defs.svh"
module test_cpu_isa_decode_tail;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [7:0]  waits = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] word = 32'h0000_0000;
    logic [31:0] seen_adr = 32'h0000_0000;
    logic [31:0] rdat, st, dat_o, mem_adr, mem_dat;
    logic        ack, mem_rd, mem_ack;
    int          err_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    always #10 clk_i = ~clk_i;
    cpu_isa_decode_tail u_cpu_isa_decode_tail (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .mem_rd_o(mem_rd), .mem_adr_o(mem_adr),
        .mem_ack_i(mem_ack), .mem_dat_i(mem_dat));
    tail_mem_model u_tail_mem_model (.clk_i(clk_i), .rd_i(mem_rd), .waits_i(waits),
        .word_i(word), .ack_o(mem_ack), .dat_o(mem_dat));
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (mem_rd) seen_adr <= mem_adr;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rdat);
    endtask
    // start an instruction, poll until done or illegal, then clear both
    task automatic run(input logic [31:0] insn);
        wb(1'b1, `A_INSN, insn);
        wb(1'b1, `A_CTRL, 32'h0000_0001);
        do wb(1'b0, `A_STAT, 32'h0000_0000); while ((rdat & 32'h0000_0006) == 32'h0000_0000);
        st = rdat;
        wb(1'b1, `A_STAT, 32'h0000_0006);
    endtask
    task automatic t_ext();
        logic [15:0] op [4] = '{16'h00A5, 16'h00E5, 16'h0085, 16'h00C5};
        logic [31:0] ex [4] = '{32'hFFFF_FF80, 32'hFFFF_8180, 32'h0000_0080, 32'h0000_8180};
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 8'h94, 32'h0000_8180);
            run({16'h0000, op[i]});
            rd_chk("ext_result", 8'h94, ex[i]);
            rd_chk("ext_cycles", `A_CYC, 32'h0000_0000);
        end
        rd_chk("ext_flags", `A_PSW, `PSW_RST);
        run(32'h0000_00A0);
        chk("zero_field", 32'h0000_0004, st & 32'h0000_0004);
    endtask
    task automatic t_xor();
        wb(1'b1, 8'h84, 32'h0000_FFFF);
        wb(1'b1, `A_PSW, 32'h0000_0024);
        run(32'hFFFF_16A1);
        rd_chk("xor_result", 8'h88, 32'h0000_0000);
        rd_chk("xor_flags", `A_PSW, 32'h0000_0021);
    endtask
    task automatic t_trap();
        wb(1'b1, `A_PC, 32'h0000_0100);
        run(32'h0100_07F1);
        rd_chk("trap_pc", `A_PC, `TRAP_HI);
        rd_chk("trap_ret", `A_EXCEPTION_RETURN_PC, 32'h0000_0104);
        rd_chk("trap_saved", `A_EXCEPTION_SAVED_STATUS, 32'h0000_0021);
        rd_chk("trap_psw", `A_PSW, 32'h0000_0061);
        rd_chk("trap_cycles", `A_CYC, 32'h0000_0002);
        wb(1'b0, `A_ECR, 32'h0000_0000);
        chk("trap_cause", 32'h0000_0051, rdat & 32'h0000_FFFF);
        run(32'h0100_07E5);
        rd_chk("trap_pc_low", `A_PC, `TRAP_LO);
    endtask
    task automatic t_bit();
        wb(1'b1, 8'h84, 32'h0000_0100);
        waits <= 8'h02;
        word <= 32'h0000_0008;
        run(32'h0004_DFC1);
        rd_chk("bit_flags", `A_PSW, 32'h0000_0060);
        rd_chk("bit_cycles", `A_CYC, 32'h0000_0204);
        chk("bit_adr", 32'h0000_0104, seen_adr);
        wb(1'b1, 8'h88, 32'h0000_0002);
        run(32'h00E6_17E1);
        rd_chk("bit_reg_flags", `A_PSW, 32'h0000_0061);
        rd_chk("bit_reg_cycles", `A_CYC, 32'h0000_0204);
        chk("bit_reg_adr", 32'h0000_0100, seen_adr);
    endtask
    task automatic t_jump();
        wb(1'b1, 8'h84, 32'h0000_0002);
        wb(1'b1, `A_PC, 32'h0000_0100);
        waits <= 8'h00;
        word <= 32'hFFFE_0000;
        run(32'h0000_0041);
        rd_chk("jump_pc", `A_PC, 32'h0000_00FE);
        rd_chk("jump_cycles", `A_CYC, 32'h0000_0004);
        chk("jump_adr", 32'h0000_0106, seen_adr);
        waits <= 8'h01;
        run(32'h0103_3F21);
        rd_chk("load_result", 8'h9C, 32'hFFFE_0000);
        rd_chk("load_cycles", `A_CYC, 32'h0000_0102);
        chk("load_adr", 32'h0000_0104, seen_adr);
    endtask
    task automatic t_list();
        wb(1'b1, `A_EXT, 32'h1234_5678);
        run(32'h001B_0780);
        rd_chk("list_ep", `A_EP, 32'h1234_5678);
        rd_chk("list_cycles", `A_CYC, 32'h0000_0003);
        wb(1'b1, `A_EXT, 32'h0000_8001);
        run(32'h00EB_0780);
        rd_chk("list_ep_sext", `A_EP, 32'hFFFF_8001);
        rd_chk("list_cycles_n", `A_CYC, 32'h0000_0004);
        wb(1'b1, `A_INSN, 32'h003D_0035);
        rd_chk("imm9_field", `A_FLD, 32'h0000_03F5);
        rd_chk("disp22_field", `A_DSP, 32'hFFF5_003C);
    endtask
    task automatic t_sr();
        wb(1'b1, 8'h90, 32'h0000_0123);
        wb(1'b1, `A_PSW, `PSW_RST);
        run(32'h0020_07E4);
        rd_chk("sr_load", `A_EXCEPTION_RETURN_PC, 32'h0000_0123);
        rd_chk("sr_load_cycles", `A_CYC, 32'h0000_0002);
        run(32'h0040_37E0);
        rd_chk("sr_store", 8'h98, 32'h0000_0123);
        rd_chk("sr_store_cycles", `A_CYC, 32'h0000_0000);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ext();
        t_xor();
        t_trap();
        t_bit();
        t_jump();
        t_list();
        t_sr();
        report_and_stop();
    end
endmodule // test_cpu_isa_decode_tail
